/* File: hw/mdd_top.v */
`timescale 1ns/10ps
`include "mdd_defines.vh"
module mdd_top #(
    parameter BCW = 6
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [2:0] i_mode_sel,
    input wire [3:0] i_direction_input_a,
    input wire [3:0] i_direction_input_b,
    input wire i_brake_pwm,
    input wire [1:0] i_digital_blank_sel,
    input wire i_chop_reference_pin,
    input wire [3:0] i_comp_trip,
    input wire i_thermal_trip_flag,
    input wire i_overcurrent_trip_flag,
    input wire i_logic_supply_ok,
    input wire i_motor_supply_ok,
    output reg [3:0] o_out_pos_hi,
    output reg [3:0] o_out_neg_hi,
    output reg [3:0] o_out_en,
    output reg [3:0] o_chop_off,
    output reg [2:0] o_mode,
    output reg o_standby,
    output reg o_trip_latched,
    output reg [1:0] o_blank_active
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire [23:0] raw_in;
    wire [23:0] syn;
    assign raw_in = {i_motor_supply_ok, i_logic_supply_ok, i_overcurrent_trip_flag, i_thermal_trip_flag,
                     i_comp_trip, i_chop_reference_pin, i_digital_blank_sel, i_brake_pwm,
                     i_direction_input_b, i_direction_input_a, i_mode_sel};

    mdd_sync2 #(.W(24)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(raw_in),
        .o_sync(syn)
    );

    wire [2:0] mode_s = syn[2:0];
    wire [3:0] dir_a = syn[6:3];
    wire [3:0] dir_b = syn[10:7];
    wire brake_s = syn[11];
    wire [1:0] dblank_s = syn[13:12];
    wire ref_s = syn[14];
    wire [3:0] comp_s = syn[18:15];
    wire tsd_s = syn[19];
    wire isd_s = syn[20];
    wire vcc_ok_s = syn[21];
    wire vm_ok_s = syn[22];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Stepper: dir_a is polarity, dir_b is output gate.
    function [1:0] step_drv;
        input pol;
        input gate;
        begin
            if (!gate)
                step_drv = `MDD_DRV_OFF;
            else if (pol)
                step_drv = `MDD_DRV_REV;
            else
                step_drv = `MDD_DRV_FWD;
        end
    endfunction

    // DC: REV means out+ high, FWD means out- high.
    function [1:0] dc_drv;
        input d1;
        input d2;
        input brk;
        begin
            if (d1 && d2)
                dc_drv = `MDD_DRV_BRAKE;
            else if (!d1 && !d2)
                dc_drv = `MDD_DRV_OFF;
            else if (!brk)
                dc_drv = `MDD_DRV_BRAKE;
            else if (d2)
                dc_drv = `MDD_DRV_FWD;
            else
                dc_drv = `MDD_DRV_REV;
        end
    endfunction

    // ------------------------------------------------------------
    // Mode capture and latched shutdown
    // ------------------------------------------------------------
    reg [2:0] mode_q;
    reg mode_valid_q;
    reg [1:0] settle_q;
    reg trip_q;
    wire supply_low = !vcc_ok_s || !vm_ok_s;

    // Mode held from first sampled value; live switching unsupported
    always @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            mode_q <= `MDD_MODE_STANDBY;
            mode_valid_q <= 1'b0;
            settle_q <= 2'h0;
        end
        else
        begin
            // Synchroniser still holds reset zeros for two edges after release
            if (settle_q != 2'h2)
                settle_q <= settle_q + 2'h1;
            else if (!mode_valid_q)
            begin
                mode_q <= mode_s;
                mode_valid_q <= 1'b1;
            end
        end
    end

    // Only reset (power-on) releases the trip latch
    always @(posedge i_clk_sys)
    begin
        if (i_rst)
            trip_q <= 1'b0;
        else if (tsd_s || isd_s)
            trip_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // Chopper reference edge and per-pair blanking
    // ------------------------------------------------------------
    reg ref_d_q;
    always @(posedge i_clk_sys)
    begin
        if (i_rst)
            ref_d_q <= 1'b0;
        else
            ref_d_q <= ref_s;
    end
    wire ref_rise = ref_s && !ref_d_q;

    // Chopper cycle spans four reference periods, so a three-period blank can end
    reg [1:0] chop_cnt_q;
    always @(posedge i_clk_sys)
    begin
        if (i_rst)
            chop_cnt_q <= 2'h0;
        else if (ref_rise)
            chop_cnt_q <= chop_cnt_q + 2'h1;
    end
    wire chop_start = ref_rise && chop_cnt_q == 2'h0;

    reg pair_ab_dc;
    reg pair_cd_dc;
    reg brk_used;
    always @*
    begin
        pair_ab_dc = 1'b0;
        pair_cd_dc = 1'b0;
        brk_used = 1'b0;
        case (mode_q)
            `MDD_MODE_DC_L2:
            begin
                pair_ab_dc = 1'b1;
                pair_cd_dc = 1'b1;
                brk_used = 1'b1;
            end
            `MDD_MODE_DC_S4:
            begin
                pair_ab_dc = 1'b1;
                pair_cd_dc = 1'b1;
            end
            `MDD_MODE_DC_L_STEP:
            begin
                pair_ab_dc = 1'b1;
                brk_used = 1'b1;
            end
            `MDD_MODE_DC_S2_STEP:
                pair_ab_dc = 1'b1;
            default:
                pair_ab_dc = 1'b0;
        endcase
    end

    wire [1:0] pair_dc = {pair_cd_dc, pair_ab_dc};
    wire [1:0] blank;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_blank
            mdd_blank #(.CW(BCW)) u_blank (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_chop_start(chop_start),
                .i_ref_edge(ref_rise),
                .i_dig_en(pair_dc[g] & dblank_s[g]),
                .o_blank(blank[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------
    reg [7:0] drv;
    reg [3:0] chop;
    wire brk_eff = brk_used ? brake_s : 1'b1;
    integer k;
    always @*
    begin
        drv = 8'h00;
        chop = 4'h0;
        case (mode_q)
            `MDD_MODE_STEP_S2:
                for (k = 0; k < 4; k = k + 1)
                    drv[2*k +: 2] = step_drv(dir_a[k], dir_b[k]);
            `MDD_MODE_STEP_L:
            begin
                drv[1:0] = step_drv(dir_a[0], dir_b[0]);
                drv[3:2] = drv[1:0];
                drv[5:4] = step_drv(dir_a[2], dir_b[2]);
                drv[7:6] = drv[5:4];
            end
            `MDD_MODE_DC_L2:
            begin
                drv[1:0] = dc_drv(dir_a[0], dir_b[0], brk_eff);
                drv[3:2] = drv[1:0];
                drv[5:4] = dc_drv(dir_a[2], dir_b[2], brk_eff);
                drv[7:6] = drv[5:4];
            end
            `MDD_MODE_DC_S4:
                for (k = 0; k < 4; k = k + 1)
                    drv[2*k +: 2] = dc_drv(dir_a[k], dir_b[k], 1'b1);
            `MDD_MODE_DC_L_STEP:
            begin
                drv[1:0] = dc_drv(dir_a[0], dir_b[0], brk_eff);
                drv[3:2] = drv[1:0];
                drv[5:4] = step_drv(dir_a[2], dir_b[2]);
                drv[7:6] = step_drv(dir_a[3], dir_b[3]);
            end
            `MDD_MODE_DC_S2_STEP:
            begin
                drv[1:0] = dc_drv(dir_a[0], dir_b[0], 1'b1);
                drv[3:2] = dc_drv(dir_a[1], dir_b[1], 1'b1);
                drv[5:4] = step_drv(dir_a[2], dir_b[2]);
                drv[7:6] = step_drv(dir_a[3], dir_b[3]);
            end
            default:
                drv = 8'h00;
        endcase
        for (k = 0; k < 4; k = k + 1)
            chop[k] = comp_s[k] & !blank[k/2];
    end

    wire halt = trip_q || supply_low || mode_q == `MDD_MODE_STANDBY || mode_q == `MDD_MODE_INHIBIT;

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_out_pos_hi <= 4'h0;
            o_out_neg_hi <= 4'h0;
            o_out_en <= 4'h0;
            o_chop_off <= 4'h0;
            o_mode <= `MDD_MODE_STANDBY;
            o_standby <= 1'b1;
            o_trip_latched <= 1'b0;
            o_blank_active <= 2'h0;
        end
        else
        begin
            for (k = 0; k < 4; k = k + 1)
            begin
                o_out_pos_hi[k] <= !halt && drv[2*k +: 2] == `MDD_DRV_REV;
                o_out_neg_hi[k] <= !halt && drv[2*k +: 2] == `MDD_DRV_FWD;
                o_out_en[k] <= !halt && drv[2*k +: 2] != `MDD_DRV_OFF;
            end
            o_chop_off <= halt ? 4'h0 : chop;
            o_mode <= mode_q;
            o_standby <= halt;
            o_trip_latched <= trip_q;
            o_blank_active <= blank;
        end
    end
endmodule

/* File: hw/mdd_defines.vh */
`ifndef MDD_DEFINES_VH
`define MDD_DEFINES_VH

// Mode select codes, {select2, select1, select0}
`define MDD_MODE_STEP_S2 3'h7
`define MDD_MODE_DC_L2 3'h6
`define MDD_MODE_STEP_L 3'h5
`define MDD_MODE_DC_S4 3'h4
`define MDD_MODE_DC_L_STEP 3'h3
`define MDD_MODE_DC_S2_STEP 3'h2
`define MDD_MODE_INHIBIT 3'h1
`define MDD_MODE_STANDBY 3'h0

// Output stage states per bridge half pair
`define MDD_DRV_OFF 2'h0
`define MDD_DRV_FWD 2'h1
`define MDD_DRV_REV 2'h2
`define MDD_DRV_BRAKE 2'h3

// Digital blank length in chopper reference periods
`define MDD_DBLANK_PERIODS 2'h3
// Analog blank, ns, and its cycle count at 100 MHz (rounded down, longest time)
`define MDD_ABLANK_NS 300
`define MDD_CLK_NS 10
// Sized to the blank counter: 300 ns over a 10 ns clock
`define MDD_ABLANK_CYC 6'h1e

`endif

/* File: hw/mdd_sync2.v */
`timescale 1ns/10ps
module mdd_sync2 #(
    parameter W = 1
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

/* File: hw/mdd_blank.v */
`timescale 1ns/10ps
`include "mdd_defines.vh"
// Blanking window for one axis pair: analog interval always, plus three
// chopper reference periods when digital blank is selected (DC only).
module mdd_blank #(
    parameter CW = 6
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_chop_start,
    input wire i_ref_edge,
    input wire i_dig_en,
    output wire o_blank
);
    reg [CW-1:0] acnt_q;
    reg [1:0] dcnt_q;

    always @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            acnt_q <= {CW{1'b0}};
            dcnt_q <= 2'h0;
        end
        else if (i_chop_start)
        begin
            acnt_q <= `MDD_ABLANK_CYC;
            dcnt_q <= i_dig_en ? `MDD_DBLANK_PERIODS : 2'h0;
        end
        else
        begin
            if (acnt_q != {CW{1'b0}})
                acnt_q <= acnt_q - {{(CW-1){1'b0}}, 1'b1};
            if (i_ref_edge && dcnt_q != 2'h0)
                dcnt_q <= dcnt_q - 2'h1;
        end
    end

    assign o_blank = (acnt_q != {CW{1'b0}}) || (dcnt_q != 2'h0);
endmodule

/* File: sim/mdd_props.sv */
`timescale 1ns/10ps
module mdd_props (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [3:0] i_direction_input_a,
    input wire [3:0] i_direction_input_b,
    input wire i_thermal_trip_flag,
    input wire i_overcurrent_trip_flag,
    input wire i_logic_supply_ok,
    input wire i_motor_supply_ok,
    input wire [3:0] o_out_pos_hi,
    input wire [3:0] o_out_neg_hi,
    input wire [3:0] o_out_en,
    input wire [3:0] o_chop_off,
    input wire [2:0] o_mode,
    input wire o_standby,
    input wire o_trip_latched,
    input wire [1:0] o_blank_active
);
    // ----
    // Pin history
    // ----
    // Two sync flops plus the output register: outputs follow pins three edges late
    reg [7:0] ab_q [1:4];
    reg [8:0] run_q;
    wire [3:0] a3 = ab_q[3][7:4];
    wire [3:0] b3 = ab_q[3][3:0];
    wire steady = (ab_q[3] == ab_q[4]) && !o_standby;
    always @(posedge i_clk_sys)
    begin
        ab_q[1] <= {i_direction_input_a, i_direction_input_b};
        ab_q[2] <= ab_q[1];
        ab_q[3] <= ab_q[2];
        ab_q[4] <= ab_q[3];
        run_q <= o_blank_active[0] ? run_q + 9'h001 : 9'h000;
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    trip_in_a: assert property ((i_thermal_trip_flag || i_overcurrent_trip_flag) |-> ##[1:5] o_trip_latched)
        else $error("trip not latched");
    trip_hold_a: assert property (o_trip_latched |=> o_trip_latched && o_standby)
        else $error("trip released");
    supply_halt_a: assert property (!(i_logic_supply_ok && i_motor_supply_ok) |-> ##[1:5] o_standby)
        else $error("no halt on low supply");
    halt_off_a: assert property (o_standby && $past(o_standby) |-> o_out_en == 4'h0)
        else $error("outputs on in standby");
    step_gate_a: assert property (o_mode == 3'h7 && steady && !$past(o_standby) |-> o_out_en == b3)
        else $error("stepper gate wrong");
    step_pol_a: assert property (o_mode == 3'h7 && steady && !$past(o_standby) |-> o_out_pos_hi == (a3 & b3))
        else $error("stepper polarity wrong");
    dc4_dir_a: assert property (o_mode == 3'h4 && steady && !$past(o_standby)
        |-> {o_out_en, o_out_pos_hi, o_out_neg_hi} == {a3 | b3, a3 & ~b3, ~a3 & b3})
        else $error("dc4 outputs wrong");
    chop_mask_a: assert property (o_blank_active[0] && $past(o_blank_active[0]) &&
        $past(o_blank_active[0], 2) |-> !o_chop_off[0])
        else $error("comparator seen in blank");
    step_blank_a: assert property (o_mode == 3'h7 && !o_blank_active[0] && run_q != 9'h000 |-> run_q == 9'h01e)
        else $error("stepper blank length wrong");
endmodule
bind mdd_top mdd_props u_props (.i_clk_sys, .i_rst, .i_direction_input_a, .i_direction_input_b,
    .i_thermal_trip_flag, .i_overcurrent_trip_flag, .i_logic_supply_ok, .i_motor_supply_ok,
    .o_out_pos_hi, .o_out_neg_hi, .o_out_en, .o_chop_off, .o_mode, .o_standby, .o_trip_latched,
    .o_blank_active);

/* File: sim/mdd_host.sv */
`timescale 1ns/10ps
// ----
// Host controller
// ----
module mdd_host #(
    parameter HALF = 20
) (
    input wire i_clk_sys,
    input wire i_por,
    input wire [2:0] i_mode_req,
    input wire [3:0] i_gate_req,
    output reg [2:0] o_mode_sel,
    output wire [3:0] o_gate,
    output reg o_ref
);
    reg [7:0] cnt_q = 8'h00;
    initial
    begin
        o_mode_sel = 3'h0;
        o_ref = 1'b0;
    end
    // Mode pins move only under reset; the reserved code is never driven
    always @(posedge i_clk_sys)
    begin
        if (i_por)
            o_mode_sel <= (i_mode_req == 3'h1) ? 3'h0 : i_mode_req;
        cnt_q <= (cnt_q == HALF - 1) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == HALF - 1)
            o_ref <= ~o_ref;
    end
    // Gates low while the device powers up
    assign o_gate = i_por ? 4'h0 : i_gate_req;
endmodule

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    reg i_clk_sys = 1'b0;
    reg i_rst = 1'b1;
    reg [2:0] m_req = 3'h0;
    reg [3:0] dir_a = 4'h0;
    reg [3:0] g_req = 4'h0;
    reg brk = 1'b1;
    reg [1:0] dbsel = 2'h0;
    reg [3:0] comp = 4'h0;
    reg therm = 1'b0;
    reg ovc = 1'b0;
    reg lsok = 1'b1;
    reg msok = 1'b1;
    wire [2:0] m_pin;
    wire [3:0] dir_b;
    wire ref_pin;
    wire [3:0] pos;
    wire [3:0] neg;
    wire [3:0] en;
    wire [3:0] chop;
    wire [2:0] mode;
    wire stby;
    wire trip;
    wire [1:0] blank;
    integer err_count = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i;
    integer w;
    integer n;
    // Row: {brake, mode}, dir_a, gate, en, pos, neg, axis mask
    reg [27:0] rows [0:10];
    always #5 i_clk_sys = ~i_clk_sys;
    mdd_host host (.i_clk_sys(i_clk_sys), .i_por(i_rst), .i_mode_req(m_req), .i_gate_req(g_req),
        .o_mode_sel(m_pin), .o_gate(dir_b), .o_ref(ref_pin));
    mdd_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mode_sel(m_pin), .i_direction_input_a(dir_a),
        .i_direction_input_b(dir_b), .i_brake_pwm(brk), .i_digital_blank_sel(dbsel),
        .i_chop_reference_pin(ref_pin), .i_comp_trip(comp), .i_thermal_trip_flag(therm),
        .i_overcurrent_trip_flag(ovc), .i_logic_supply_ok(lsok), .i_motor_supply_ok(msok),
        .o_out_pos_hi(pos), .o_out_neg_hi(neg), .o_out_en(en), .o_chop_off(chop), .o_mode(mode),
        .o_standby(stby), .o_trip_latched(trip), .o_blank_active(blank));
    // ----
    // Helpers
    // ----
    task stop_test;
    begin
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    always @(posedge i_clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            err_count = err_count + 1;
            stop_test;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task tick(input integer k);
        repeat (k) @(posedge i_clk_sys);
    endtask
    task step;
    begin
        @(posedge i_clk_sys);
        #1;
    end
    endtask
    // Mode is only taken at reset, so every mode change costs a reset
    task do_reset(input [2:0] m);
    begin
        tick(1);
        m_req <= m;
        i_rst <= 1'b1;
        tick(3);
        i_rst <= 1'b0;
        tick(6);
        #1;
    end
    endtask
    // Skip any blank in progress, then count one whole window
    task blank_len(input integer k);
    begin
        n = 0;
        for (w = 0; w < 300 && blank[k] === 1'b1; w = w + 1)
            step;
        for (w = 0; w < 300 && blank[k] === 1'b0; w = w + 1)
            step;
        for (w = 0; w < 300 && blank[k] === 1'b1; w = w + 1)
        begin
            step;
            n = n + 1;
        end
    end
    endtask
    // ----
    // Sequence
    // ----
    initial
    begin
        rows[0] = 28'hf5ff5af;
        rows[1] = 28'hfa3321f;
        rows[2] = 28'h75ff5af;
        rows[3] = 28'hccae42f;
        rows[4] = 28'h4cae42f;
        rows[5] = 28'he011011;
        rows[6] = 28'h6011001;
        rows[7] = 28'he101101;
        rows[8] = 28'h6101001;
        rows[9] = 28'he111001;
        rows[10] = 28'h6000001;
        for (i = 0; i < 11; i = i + 1)
        begin
            if (i == 0 || rows[i][26:24] != rows[i-1][26:24])
                do_reset(rows[i][26:24]);
            tick(1);
            dir_a <= rows[i][23:20];
            g_req <= rows[i][19:16];
            brk <= rows[i][27];
            tick(4);
            #1;
            chk({en, pos, neg} & {3{rows[i][3:0]}}, rows[i][15:4] & {3{rows[i][3:0]}});
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            do_reset(i[2:0]);
            chk({mode, stby}, {(i == 1) ? 3'h0 : i[2:0], i < 2});
        end
        for (i = 0; i < 2; i = i + 1)
        begin
            do_reset(3'h7);
            therm <= (i == 0);
            ovc <= (i == 1);
            tick(1);
            therm <= 1'b0;
            ovc <= 1'b0;
            tick(6);
            #1;
            chk({trip, stby}, 16'h0003);
        end
        do_reset(3'h7);
        chk({trip, stby}, 16'h0000);
        for (i = 0; i < 3; i = i + 1)
        begin
            tick(1);
            lsok <= (i != 0);
            msok <= (i != 1);
            tick(5);
            #1;
            chk(stby, i < 2);
        end
        tick(1);
        comp <= 4'hf;
        dbsel <= 2'h3;
        do_reset(3'h7);
        blank_len(0);
        chk(n, 16'h001e);
        chk(chop[0], 16'h0001);
        tick(1);
        dbsel <= 2'h1;
        do_reset(3'h4);
        blank_len(1);
        chk(n, 16'h001e);
        blank_len(0);
        chk(n > 30, 16'h0001);
        stop_test;
    end
endmodule
